// ### rtl/cfd_map.vh
// Register map, field positions, reset values and timing for the fault detector
`ifndef CFD_MAP_VH
`define CFD_MAP_VH

// Extended register addresses
`define CFD_CTL_ADDR 12'h122
`define CFD_THR_ADDR 12'h123
`define CFD_CHK_ADDR 12'h124

// Reset values
`define CFD_CTL_RST 8'h00
`define CFD_THR_RST 8'h8B
`define CFD_CHK_RST 8'h84

// Measurement control field positions
`define CFD_ACT_BIT 7
`define CFD_EDGE_BIT 6
`define CFD_SEL_HI_BIT 5
`define CFD_SEL_LO_BIT 4
`define CFD_ZX1_EN_BIT 3
`define CFD_ZX2_EN_BIT 2
`define CFD_PF_SEL_BIT 1
`define CFD_ZC_BYP_BIT 0

// Fault check control field positions
`define CFD_CHK_EN_BIT 7
`define CFD_RATIO_MSB 3
`define CFD_RATIO_LSB 0

// Threshold scale: one threshold LSB is two to this power current LSBs (a left shift)
`define CFD_THR_SHIFT 7

// Fault filter time and clock rate
`define CFD_FILT_MS 3000
`define CFD_CLK_KHZ 40000

`endif

// ### rtl/cfd_fault_filter.v
// Misdetection filter: output follows raw status only after it stays put
`timescale 1ns/1ps
module cfd_fault_filter #(
  parameter [31:0] FILT_CYC = 32'd120000000
) (
  clk,
  rst,
  ce,
  raw_fault,
  filt_fault
);
  input wire clk;
  input wire rst;
  input wire ce;
  input wire raw_fault;
  output reg filt_fault;

  // One-hot states of the filtered status
  localparam [1:0] ST_NORM = 2'b01;
  localparam [1:0] ST_FAULT = 2'b10;

  reg [1:0] state_reg; // Filtered status state
  reg [31:0] cnt_reg; // Cycles the raw status has disagreed

  // Filter state machine with stability counter
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_NORM;
      cnt_reg <= 32'h00000000;
      filt_fault <= 1'b0;
    end else if (ce) begin
      case (state_reg)
        ST_NORM: begin
          // Count while raw reports fault, restart on any glitch
          if (!raw_fault) begin
            cnt_reg <= 32'h00000000;
          end else if (cnt_reg >= FILT_CYC - 32'd1) begin
            cnt_reg <= 32'h00000000;
            state_reg <= ST_FAULT;
            filt_fault <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg + 32'd1;
          end
        end
        ST_FAULT: begin
          // Count while raw reports normal
          if (raw_fault) begin
            cnt_reg <= 32'h00000000;
          end else if (cnt_reg >= FILT_CYC - 32'd1) begin
            cnt_reg <= 32'h00000000;
            state_reg <= ST_NORM;
            filt_fault <= 1'b0;
          end else begin
            cnt_reg <= cnt_reg + 32'd1;
          end
        end
        default: begin
          // Recover from an illegal code
          state_reg <= ST_NORM;
          cnt_reg <= 32'h00000000;
          filt_fault <= 1'b0;
        end
      endcase
    end
  end
endmodule // cfd_fault_filter

// ### rtl/cfd_top.v
// Current fault detection and measurement control, extended register port
//
// Contract
// - Control bit 7 reports active current channel
// - Irq on fault entry or exit per select
// - Select 00 or 11 follows fault status
// - Select 01 forces channel 1, 10 channel 2
// - Zero-cross outputs gated by own enables
// - Result holds period or frequency per select
// - Zero-cross from filter or converter per bypass
// - Eight-bit minimum threshold resets to 8BH
// - Check disabled means no fault detection
// - Larger current at or below threshold: none
// - Ratio field decoded by priority to shift
// - Fault with larger inactive channel swaps channels under select 00 or 11
// - Irq and switching filtered about three seconds
// - Three-wire mode disables fault detection
`timescale 1ns/1ps
`include "cfd_map.vh"
module cfd_top #(
  parameter [31:0] FILT_CYC = `CFD_FILT_MS * `CFD_CLK_KHZ
) (
  clk,
  rst,
  ce,
  sfr_addr,
  sfr_wr,
  sfr_rd,
  sfr_wdata,
  sfr_rdata,
  sample_tick,
  ich1_mag,
  ich2_mag,
  three_wire_mode_bit,
  zc_raw1,
  zc_raw2,
  zc_lpf1,
  zc_lpf2,
  meas_done,
  period_meas,
  freq_meas,
  period_freq_result,
  zero_cross_out1,
  zero_cross_out2,
  active_channel_flag,
  fault_status,
  fault_mode_irq
);
  input wire clk;
  input wire rst;
  input wire ce;
  input wire [11:0] sfr_addr;
  input wire sfr_wr;
  input wire sfr_rd;
  input wire [7:0] sfr_wdata;
  output reg [7:0] sfr_rdata;
  input wire sample_tick;
  input wire [23:0] ich1_mag;
  input wire [23:0] ich2_mag;
  input wire three_wire_mode_bit;
  input wire zc_raw1;
  input wire zc_raw2;
  input wire zc_lpf1;
  input wire zc_lpf2;
  input wire meas_done;
  input wire [15:0] period_meas;
  input wire [15:0] freq_meas;
  output reg [15:0] period_freq_result;
  output reg zero_cross_out1;
  output reg zero_cross_out2;
  output reg active_channel_flag;
  output reg fault_status;
  output reg fault_mode_irq;

  // Priority decode of the ratio field into a right shift
  function [2:0] ratio_shift;
    input [3:0] field;
    begin
      if (field[3]) begin
        ratio_shift = 3'd3; // 1/8
      end else if (field[2]) begin
        ratio_shift = 3'd4; // 1/16
      end else if (field[1]) begin
        ratio_shift = 3'd5; // 1/32
      end else if (field[0]) begin
        ratio_shift = 3'd6; // 1/64
      end else begin
        ratio_shift = 3'd4; // 1/16 for all zero
      end
    end
  endfunction

  // Absolute difference of two magnitudes
  function [23:0] abs_diff;
    input [23:0] a;
    input [23:0] b;
    begin
      abs_diff = (a >= b) ? (a - b) : (b - a);
    end
  endfunction

  reg [6:0] ctl_reg; // Writable control bits 6..0
  reg [7:0] thr_reg; // Minimum current threshold
  reg chk_en_reg; // Fault check enable
  reg [3:0] ratio_reg; // Difference ratio field
  reg raw_fault_reg; // Unfiltered fault status
  reg filt_d_reg; // Previous filtered status
  wire filt_fault; // Filtered fault status
  localparam [7:0] CTL_RST = `CFD_CTL_RST; // Control reset value
  localparam [7:0] CHK_RST = `CFD_CHK_RST; // Check control reset value

  // Decoded control fields
  wire edge_sel = ctl_reg[`CFD_EDGE_BIT];
  wire [1:0] ch_sel = {ctl_reg[`CFD_SEL_HI_BIT], ctl_reg[`CFD_SEL_LO_BIT]};
  wire auto_sel = (ch_sel == 2'b00) || (ch_sel == 2'b11);

  // Active and inactive channel values
  wire [23:0] act_i = active_channel_flag ? ich2_mag : ich1_mag;
  wire [23:0] inact_i = active_channel_flag ? ich1_mag : ich2_mag;
  wire [23:0] max_i = (ich1_mag >= ich2_mag) ? ich1_mag : ich2_mag;
  wire [23:0] diff_i = abs_diff(ich1_mag, ich2_mag);
  wire [23:0] limit_i = act_i >> ratio_shift(ratio_reg);
  wire [23:0] thr_i = {9'h000, thr_reg, 7'h00};

  // Detection only when enabled, two-wire and above threshold
  wire detect_ok = chk_en_reg && !three_wire_mode_bit && (max_i > thr_i);

  // Register writes from the extended register port
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_reg <= CTL_RST[6:0];
      thr_reg <= `CFD_THR_RST;
      chk_en_reg <= CHK_RST[`CFD_CHK_EN_BIT];
      ratio_reg <= CHK_RST[`CFD_RATIO_MSB:`CFD_RATIO_LSB];
    end else if (ce && sfr_wr) begin
      case (sfr_addr)
        `CFD_CTL_ADDR: begin
          ctl_reg <= sfr_wdata[6:0]; // Bit 7 is status only
        end
        `CFD_THR_ADDR: begin
          thr_reg <= sfr_wdata;
        end
        `CFD_CHK_ADDR: begin
          // Bits 6..4 are not stored
          chk_en_reg <= sfr_wdata[`CFD_CHK_EN_BIT];
          ratio_reg <= sfr_wdata[`CFD_RATIO_MSB:`CFD_RATIO_LSB];
        end
        default: begin
          // Unmapped write ignored
        end
      endcase
    end
  end

  // Registered read data, zero for unmapped addresses
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
    end else if (ce && sfr_rd) begin
      case (sfr_addr)
        `CFD_CTL_ADDR: begin
          sfr_rdata <= {active_channel_flag, ctl_reg};
        end
        `CFD_THR_ADDR: begin
          sfr_rdata <= thr_reg;
        end
        `CFD_CHK_ADDR: begin
          sfr_rdata <= {chk_en_reg, 3'h0, ratio_reg};
        end
        default: begin
          sfr_rdata <= 8'h00;
        end
      endcase
    end
  end

  // Raw fault evaluation once per sample, held while detection is off
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      raw_fault_reg <= 1'b0;
    end else if (ce && sample_tick && detect_ok) begin
      raw_fault_reg <= (diff_i > limit_i);
    end
  end

  // Misdetection filter on the fault status
  cfd_fault_filter #(
    .FILT_CYC(FILT_CYC)
  ) u_filter (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .raw_fault(raw_fault_reg),
    .filt_fault(filt_fault)
  );

  // Status edge detection, interrupt pulse and channel choice
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      filt_d_reg <= 1'b0;
      fault_status <= 1'b0;
      fault_mode_irq <= 1'b0;
      active_channel_flag <= 1'b0;
    end else if (ce) begin
      filt_d_reg <= filt_fault;
      fault_status <= filt_fault;
      // One-cycle pulse on the selected transition
      if (edge_sel) begin
        fault_mode_irq <= filt_d_reg && !filt_fault;
      end else begin
        fault_mode_irq <= !filt_d_reg && filt_fault;
      end
      if (ch_sel == 2'b01) begin
        active_channel_flag <= 1'b0;
      end else if (ch_sel == 2'b10) begin
        active_channel_flag <= 1'b1;
      end else if (auto_sel && filt_fault && sample_tick && (inact_i > act_i)) begin
        // Swap to the larger channel while in fault
        active_channel_flag <= !active_channel_flag;
      end
    end
  end

  // Zero-cross outputs and period or frequency result
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      zero_cross_out1 <= 1'b0;
      zero_cross_out2 <= 1'b0;
      period_freq_result <= 16'h0000;
    end else if (ce) begin
      if (ctl_reg[`CFD_ZC_BYP_BIT]) begin
        // Bypass: straight from the converter
        zero_cross_out1 <= ctl_reg[`CFD_ZX1_EN_BIT] && zc_raw1;
        zero_cross_out2 <= ctl_reg[`CFD_ZX2_EN_BIT] && zc_raw2;
      end else begin
        // Normal: from the low-pass filter
        zero_cross_out1 <= ctl_reg[`CFD_ZX1_EN_BIT] && zc_lpf1;
        zero_cross_out2 <= ctl_reg[`CFD_ZX2_EN_BIT] && zc_lpf2;
      end
      if (meas_done) begin
        if (ctl_reg[`CFD_PF_SEL_BIT]) begin
          period_freq_result <= freq_meas;
        end else begin
          period_freq_result <= period_meas;
        end
      end
    end
  end
endmodule // cfd_top

// ### test/cfd_asserts.sv
// Port-level checker for the fault detector
`timescale 1ns/1ps
module cfd_asserts (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire [11:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  input wire [7:0] sfr_rdata,
  input wire zc_raw1,
  input wire zc_raw2,
  input wire zc_lpf1,
  input wire zc_lpf2,
  input wire meas_done,
  input wire [15:0] period_meas,
  input wire [15:0] freq_meas,
  input wire [15:0] period_freq_result,
  input wire zero_cross_out1,
  input wire zero_cross_out2,
  input wire active_channel_flag,
  input wire fault_status,
  input wire fault_mode_irq
);
  reg [7:0] ctl_reg; // Shadow of control writes
  wire ctl_wr = ce && sfr_wr && sfr_addr == 12'h122; // Control write taken
  wire fs_chg; // Fault status moved this cycle
  // Follow software writes to the control register
  always @(posedge clk or posedge rst) begin
    if (rst) ctl_reg <= 8'h00;
    else if (ctl_wr) ctl_reg <= sfr_wdata;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_irq_pulse; fault_mode_irq |=> !fault_mode_irq; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq wider than a cycle");
  property p_irq_cause;
    fault_mode_irq |-> fault_status != $past(fault_status) && fault_status != $past(ctl_reg[6]);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without its edge");
  property p_irq_due;
    fault_status != $past(fault_status) && fault_status != $past(ctl_reg[6]) |-> fault_mode_irq;
  endproperty
  a_irq_due: assert property (p_irq_due) else $error("irq missing on edge");
  property p_sel_fixed;
    ctl_wr && (sfr_wdata[5] ^ sfr_wdata[4]) |-> ##2 active_channel_flag == $past(sfr_wdata[5], 2);
  endproperty
  a_sel_fixed: assert property (p_sel_fixed) else $error("fixed channel ignored");
  property p_zc1;
    ce |-> zero_cross_out1 == $past(ctl_reg[3] & (ctl_reg[0] ? zc_raw1 : zc_lpf1));
  endproperty
  a_zc1: assert property (p_zc1) else $error("zero cross 1 wrong");
  property p_zc2;
    ce |-> zero_cross_out2 == $past(ctl_reg[2] & (ctl_reg[0] ? zc_raw2 : zc_lpf2));
  endproperty
  a_zc2: assert property (p_zc2) else $error("zero cross 2 wrong");
  property p_result;
    meas_done |=> period_freq_result == $past(ctl_reg[1] ? freq_meas : period_meas);
  endproperty
  a_result: assert property (p_result) else $error("result source wrong");
  property p_rd_ctl;
    sfr_rd && sfr_addr == 12'h122 |=> sfr_rdata == {$past(active_channel_flag), $past(ctl_reg[6:0])};
  endproperty
  a_rd_ctl: assert property (p_rd_ctl) else $error("control readback wrong");
  property p_rd_chk; sfr_rd && sfr_addr == 12'h124 |=> sfr_rdata[6:4] == 3'b000; endproperty
  a_rd_chk: assert property (p_rd_chk) else $error("check bits 6-4 not zero");
  c_irq: cover property (fault_mode_irq);
  c_swap: cover property ($rose(active_channel_flag));
  c_meas: cover property (meas_done);
endmodule // cfd_asserts

bind cfd_top cfd_asserts cfd_asserts_inst (.clk, .rst, .ce, .sfr_addr, .sfr_wr, .sfr_rd,
  .sfr_wdata, .sfr_rdata, .zc_raw1, .zc_raw2, .zc_lpf1, .zc_lpf2, .meas_done, .period_meas,
  .freq_meas, .period_freq_result, .zero_cross_out1, .zero_cross_out2, .active_channel_flag,
  .fault_status, .fault_mode_irq);

// ### test/testbench.sv
// Self-checking bench for the fault detector
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks = total_checks + 1; if ((ex) !== (got)) begin \
  n_mismatch = n_mismatch + 1; $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module testbench;
  reg clk, rst = 1'b1; // Clock and reset
  reg ce = 1'b1; // Clock enable
  reg sfr_wr = 1'b0, sfr_rd = 1'b0, meas_done = 1'b0, sample_tick = 1'b0, three_wire = 1'b0;
  reg zc_raw1 = 1'b0, zc_raw2 = 1'b0, zc_lpf1 = 1'b0, zc_lpf2 = 1'b0; // Zero-cross inputs
  reg [11:0] sfr_addr = 12'h000;
  reg [7:0] sfr_wdata = 8'h00;
  reg [23:0] ich1_mag = 24'h000000, ich2_mag = 24'h000000; // Channel magnitudes
  reg [15:0] period_meas = 16'h0000, freq_meas = 16'h0000;
  wire [7:0] sfr_rdata;
  wire [15:0] period_freq_result;
  wire zero_cross_out1, zero_cross_out2, active_channel_flag, fault_status, fault_mode_irq;
  integer n_mismatch = 0, total_checks = 0, irq_cnt = 0, tick_cnt = 0, i, s;
  reg [3:0] c; // Ratio code under test
  // Short filter keeps the run brief
  cfd_top #(.FILT_CYC(32'd8)) cfd_top_inst (.clk, .rst, .ce, .sfr_addr, .sfr_wr,
    .sfr_rd, .sfr_wdata, .sfr_rdata, .sample_tick, .ich1_mag, .ich2_mag,
    .three_wire_mode_bit(three_wire), .zc_raw1, .zc_raw2, .zc_lpf1, .zc_lpf2, .meas_done,
    .period_meas, .freq_meas, .period_freq_result, .zero_cross_out1, .zero_cross_out2,
    .active_channel_flag, .fault_status, .fault_mode_irq);
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Sample tick every fourth cycle
  always @(negedge clk) begin
    tick_cnt <= tick_cnt + 1;
    sample_tick <= (tick_cnt % 4 == 0);
  end
  // Count interrupt pulses
  always @(posedge clk) if (fault_mode_irq) irq_cnt <= irq_cnt + 1;
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
        $display("Testbench passed");
      end else begin
        $display("Testbench failed");
      end
      $finish;
    end
  endtask
  task wr(input [11:0] a, input [7:0] d);
    begin
      @(negedge clk);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge clk);
      sfr_wr = 1'b0;
    end
  endtask
  task rd(input [11:0] a, input [7:0] e);
    begin
      @(negedge clk);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge clk);
      sfr_rd = 1'b0;
      `CHK("sfr_rdata", e, sfr_rdata)
    end
  endtask
  // Status must stay normal for several ticks
  task hold_normal;
    begin
      repeat (24) @(negedge clk);
      `CHK("fault_status", 1'b0, fault_status)
    end
  endtask
  // Bounded wait for a status change, then filter delay and irq count
  task wait_fault(input v, input integer ei);
    integer n, i0;
    begin
      n = 0;
      i0 = irq_cnt;
      while (fault_status !== v && n < 80) begin
        @(negedge clk);
        n = n + 1;
      end
      if (n >= 80) begin
        n_mismatch = n_mismatch + 1;
        give_verdict;
      end
      // Let the pulse launched with the status change reach the counter
      @(negedge clk);
      `CHK("filter_delay", 1'b1, n > 8)
      `CHK("irq_count", ei, irq_cnt - i0)
    end
  endtask
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    rd(12'h122, 8'h00);
    rd(12'h123, 8'h8B);
    rd(12'h124, 8'h84);
    rd(12'h125, 8'h00);
    // Clock enable low: a write must leave no trace
    ce = 1'b0;
    wr(12'h123, 8'h11);
    ce = 1'b1;
    rd(12'h123, 8'h8B);
    wr(12'h124, 8'hFF);
    rd(12'h124, 8'h8F);
    wr(12'h123, 8'h55);
    rd(12'h123, 8'h55);
    wr(12'h123, 8'h8B);
    wr(12'h124, 8'h84);
    // Output gating and filter bypass, all combinations with both enables set alike
    for (i = 0; i < 8; i = i + 1) begin
      wr(12'h122, {4'h0, i[0], i[0], 1'b0, i[1]});
      zc_raw1 = i[2];
      zc_raw2 = i[2];
      zc_lpf1 = ~i[2];
      zc_lpf2 = ~i[2];
      repeat (2) @(negedge clk);
      `CHK("zero_cross_out1", i[0] & (i[1] ? i[2] : ~i[2]), zero_cross_out1)
      `CHK("zero_cross_out2", i[0] & (i[1] ? i[2] : ~i[2]), zero_cross_out2)
    end
    // Period or frequency into the result
    for (i = 0; i < 2; i = i + 1) begin
      wr(12'h122, {6'h00, i[0], 1'b0});
      period_meas = 16'h05A7;
      freq_meas = 16'h03C0;
      meas_done = 1'b1;
      @(negedge clk);
      meas_done = 1'b0;
      @(negedge clk);
      `CHK("period_freq_result", i[0] ? 16'h03C0 : 16'h05A7, period_freq_result)
    end
    // Automatic selection: difference at the ratio, then past it
    wr(12'h122, 8'h00);
    ich1_mag = 24'h010000;
    ich2_mag = 24'h00F000;
    hold_normal;
    ich2_mag = 24'h00EFFF;
    wait_fault(1'b1, 1);
    `CHK("active_channel_flag", 1'b0, active_channel_flag)
    ich2_mag = 24'h012000;
    repeat (16) @(negedge clk);
    `CHK("active_channel_flag", 1'b1, active_channel_flag)
    rd(12'h122, 8'h80);
    wr(12'h122, 8'h40);
    ich2_mag = 24'h010000;
    wait_fault(1'b0, 1);
    // Fixed selection lands one edge after the control register
    wr(12'h122, 8'h10);
    @(negedge clk);
    `CHK("active_channel_flag", 1'b0, active_channel_flag)
    wr(12'h122, 8'h20);
    @(negedge clk);
    `CHK("active_channel_flag", 1'b1, active_channel_flag)
    wr(12'h122, 8'h10);
    // Each one-hot ratio code and all zero on both sides of its boundary
    for (i = 0; i < 5; i = i + 1) begin
      c = (i < 4) ? (4'h8 >> i) : 4'h0;
      s = (i == 4) ? 4 : i + 3;
      wr(12'h124, {4'h8, c});
      ich2_mag = 24'h010000 - (24'h010000 >> s);
      hold_normal;
      ich2_mag = ich2_mag - 24'h000001;
      wait_fault(1'b1, 1);
      ich2_mag = 24'h010000;
      wait_fault(1'b0, 0);
    end
    // Detection off: check disabled, three-wire, at threshold
    wr(12'h124, 8'h04);
    ich2_mag = 24'h000000;
    hold_normal;
    wr(12'h122, 8'h00);
    wr(12'h124, 8'h84);
    three_wire = 1'b1;
    hold_normal;
    three_wire = 1'b0;
    ich1_mag = 24'h004580;
    hold_normal;
    ich1_mag = 24'h004581;
    wait_fault(1'b1, 1);
    give_verdict;
  end
endmodule // testbench
